//--- avg_engine_pkg.sv
// constants, encodings and helpers for the spectrum averaging engine
// assumes a single processing clock; apb offsets are byte addresses
package avg_engine_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_OVL = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_DONE = 8'h14;
  localparam logic [7:0] ADDR_OVST = 8'h18;
  localparam logic [7:0] ADDR_EXPK = 8'h1c;

  localparam int unsigned CTRL_LIN_BIT = 3;
  localparam int unsigned CTRL_DISC_BIT = 4;
  localparam int unsigned CTRL_QUICK_BIT = 5;
  localparam int unsigned CTRL_APPR_LSB = 6;
  localparam int unsigned CMD_HALT_BIT = 0;
  localparam int unsigned CMD_RESTART_BIT = 1;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [14:0] COUNT_RESET = 15'h0001;
  localparam logic [14:0] COUNT_MIN = 15'h0001;
  localparam logic [14:0] EXPON_COUNT_MAX = 15'h4000;
  localparam logic [6:0] OVL_RESET_PCT = 7'h00;
  localparam logic [6:0] OVL_MAX_PCT = 7'h5a;
  localparam logic [6:0] PCT_FULL = 7'h64;

  typedef enum logic [2:0] {
    MODE_OFF       = 3'h0,
    MODE_STABLE    = 3'h1,
    MODE_EXPON     = 3'h2,
    MODE_PEAK_HOLD = 3'h3,
    MODE_PEAK_CONT = 3'h4
  } avg_mode_t;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_PAUSED = 3'b010,
    ST_DONE   = 3'b100
  } run_state_t;

  // zero reads as one; exponential caps the count at its limit
  function automatic logic [14:0] clamp_count(input logic [14:0] v,
                                              input logic expon);
    logic [14:0] r;
    r = (v < COUNT_MIN) ? COUNT_MIN : v;
    if (expon && r > EXPON_COUNT_MAX) r = EXPON_COUNT_MAX;
    return r;
  endfunction

  // exponent of the next power of two at or above the count
  function automatic logic [3:0] expon_shift(input logic [14:0] cnt);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 0; i < 15; i++) begin
      if ((16'h1 << i) < {1'b0, cnt}) k = 4'(i + 1);
    end
    return k;
  endfunction

endpackage

//--- seq_unsigned_divider.sv
// restoring divider, one quotient bit per clock
// assumes the divisor is never zero and start only while idle
`timescale 1ns/1ps
module seq_unsigned_divider #(
  parameter int unsigned NW = 25,
  parameter int unsigned DW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic [NW-1:0] dividend,
  input  wire logic [DW-1:0] divisor,
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quotient
);
  localparam int unsigned CW = $clog2(NW + 1);
  logic [DW-1:0] rem_ff;
  logic [CW-1:0] cnt_ff;
  logic [DW:0]   trial;

  assign trial = {rem_ff, quotient[NW-1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_ff <= '0;
      quotient <= '0;
      cnt_ff <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_ff <= '0;
        quotient <= dividend;
        cnt_ff <= CW'(NW);
        busy <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, divisor}) begin
          rem_ff <= DW'(trial - {1'b0, divisor});
          quotient <= {quotient[NW-2:0], 1'b1};
        end else begin
          rem_ff <= trial[DW-1:0];
          quotient <= {quotient[NW-2:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == CW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // seq_unsigned_divider

//--- overlap_percent_search.sv
// tracks the largest overlap percent, up to cap, that the record fill
// time leaves room for once the gap is spent; moves one step per clock
`timescale 1ns/1ps
module overlap_percent_search
  import avg_engine_pkg::*;
#(
  parameter int unsigned CW = 32
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [6:0]    cap,
  input  wire logic [CW-1:0] fill,
  input  wire logic [CW-1:0] gap,
  output logic [6:0]         pct
);
  logic [CW+6:0] limit;
  logic [CW+6:0] prod;
  logic [CW+6:0] prod_up;

  assign limit = (fill > gap) ?
                 (CW+7)'(fill - gap) * (CW+7)'(PCT_FULL) : '0;
  assign prod = (CW+7)'(pct) * (CW+7)'(fill);
  assign prod_up = prod + (CW+7)'(fill);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pct <= OVL_RESET_PCT;
    // no room unless fill exceeds the gap, so a zero fill always means zero
    end else if (pct > cap
                 || (pct != 7'h00 && (fill <= gap || prod > limit))) begin
      pct <= pct - 7'h01;
    end else if (pct < cap && fill > gap && prod_up <= limit) begin
      pct <= pct + 7'h01;
    end
  end
endmodule // overlap_percent_search

//--- spectrum_averaging_engine.sv
// averaging engine: stable, exponential and peak functions per line
// assumes upstream sends a record_valid strobe, then LINES samples
//
// How it works
// - average count 1..32767 sets stop target
// - exponential caps the count at 16384
// - off: single records, overwrite, ignore reject/approval
// - off: largest achievable overlap, setting ignored
// - stable: running mean, equal weights
// - stable: show intermediates unless quick, stop at count
// - exponential constant is next power of two
// - exponential: old plus new-minus-old over 2^n
// - exponential never stops on count
// - exponential: stable for first 2^n records
// - linear select picks time or power quantities; code only uses it to flag a peak function as a config error
// - peak hold: per-line max, stops at count
// - peak continuous: per-line max, runs until paused
// - pause after current record; resume; restart
// - overlap setting 0..90, zero after reset
// - overlap only when trigger is free-running
// - achieved overlap capped, measured on last two
// - overlap only if fill exceeds processing time
// - discard overrange records, flag, keep counting clean
// - picking averaging while unaveraged restarts; code restarts only in the run state, not when paused or done
// - averaging off mid-measurement pauses it
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module spectrum_averaging_engine
  import avg_engine_pkg::*;
#(
  parameter int unsigned DATA_W = 24,
  parameter int unsigned LINES  = 1024,
  parameter int unsigned LINE_W = 10
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              trigger_free_run,
  input  wire logic [31:0]       record_fill_cycles,
  input  wire logic              record_valid,
  input  wire logic              record_overrange,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] sample_data,
  output logic                   sample_ready,
  output logic [6:0]             overlap_grant_pct,
  output logic                   record_rejected,
  output logic                   result_valid,
  output logic [LINE_W-1:0]      result_line,
  output logic [DATA_W-1:0]      result_data,
  output logic                   average_complete,
  output logic                   measurement_halted
);
  localparam int unsigned NW = DATA_W + 1;

  logic [7:0]        ctrl_ff;
  logic [14:0]       count_ff;
  logic [6:0]        ovl_cfg_ff;
  run_state_t        state_ff, nxt_state;
  logic [15:0]       done_ff;
  logic              pause_pend_ff;
  logic              rec_act_ff, rec_skip_ff;
  logic [LINE_W-1:0] line_ff;
  logic              div_wait_ff, div_last_ff, div_neg_ff;
  logic [LINE_W-1:0] div_line_ff;
  logic [DATA_W-1:0] div_old_ff;
  logic [31:0]       proc_cnt_ff, proc_ff, gap_cnt_ff, gap_ff;
  logic [6:0]        ovl_achieved;
  logic [DATA_W-1:0] acc_mem [LINES];

  avg_mode_t   mode;
  logic        lin_sel, disc_en, quick_en, cfg_err;
  logic        is_off, is_stable, is_expon, is_peak, counted;
  logic [14:0] target;
  logic [3:0]  exp_k;
  logic        wr_en, ctrl_wr, halt_cmd, start, sel_avg, sel_off;
  logic        accept_rec, discard, take, last_take, use_div;
  logic        direct_wr, rec_done, final_rec, publish;
  logic        div_start, div_busy, div_done;
  logic [NW-1:0]     div_q, diff, mag;
  logic [DATA_W-1:0] old_val, new_val, wr_val;
  logic [LINE_W-1:0] wr_line;
  logic              wr_fire;
  logic [6:0]        grant_cap;
  logic [31:0]       grant_fill;

  // configuration decode
  assign mode = avg_mode_t'(ctrl_ff[2:0]);
  assign lin_sel = ctrl_ff[CTRL_LIN_BIT];
  assign disc_en = ctrl_ff[CTRL_DISC_BIT];
  assign quick_en = ctrl_ff[CTRL_QUICK_BIT];
  assign is_off = (mode == MODE_OFF);
  assign is_stable = (mode == MODE_STABLE);
  assign is_expon = (mode == MODE_EXPON);
  assign is_peak = (mode == MODE_PEAK_HOLD) || (mode == MODE_PEAK_CONT);
  assign counted = is_stable || (mode == MODE_PEAK_HOLD);
  // peak functions need the power quantity path
  assign cfg_err = (is_peak && lin_sel) || (ctrl_ff[2:0] > 3'h4);
  assign target = clamp_count(count_ff, is_expon);
  assign exp_k = expon_shift(target);

  // apb slave: zero wait states, read data latched in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  always_comb begin
    case (paddr)
      ADDR_CTRL, ADDR_COUNT, ADDR_OVL, ADDR_CMD,
      ADDR_STAT, ADDR_DONE, ADDR_OVST, ADDR_EXPK: pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL:  prdata <= {24'h0, ctrl_ff};
        ADDR_COUNT: prdata <= {17'h0, count_ff};
        ADDR_OVL:   prdata <= {25'h0, ovl_cfg_ff};
        ADDR_STAT:  prdata <= {24'h0, cfg_err, pause_pend_ff, rec_act_ff,
                               2'h0, state_ff};
        ADDR_DONE:  prdata <= {16'h0, done_ff};
        ADDR_OVST:  prdata <= {17'h0, ovl_achieved, 1'b0,
                               overlap_grant_pct};
        ADDR_EXPK:  prdata <= {28'h0, exp_k};
        default:    prdata <= '0;
      endcase
    end
  end

  assign ctrl_wr = wr_en && (paddr == ADDR_CTRL);
  assign halt_cmd = wr_en && (paddr == ADDR_CMD) && pwdata[CMD_HALT_BIT];
  assign sel_avg = ctrl_wr && is_off && (pwdata[2:0] != MODE_OFF);
  assign sel_off = ctrl_wr && !is_off && (pwdata[2:0] == MODE_OFF);
  assign start = (wr_en && (paddr == ADDR_CMD) && pwdata[CMD_RESTART_BIT])
                 || (sel_avg && state_ff == ST_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      count_ff <= COUNT_RESET;
      ovl_cfg_ff <= OVL_RESET_PCT;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) ctrl_ff <= pwdata[7:0];
      if (paddr == ADDR_COUNT) count_ff <= pwdata[14:0];
      if (paddr == ADDR_OVL) begin
        ovl_cfg_ff <= (pwdata[31:7] != 25'h0 || pwdata[6:0] > OVL_MAX_PCT) ?
                      OVL_MAX_PCT : pwdata[6:0];
      end
    end
  end

  // record admission; a record seen while not admitted is skipped whole
  assign discard = record_overrange && disc_en && !is_off;
  assign accept_rec = record_valid && state_ff == ST_RUN && !rec_act_ff
                      && !div_wait_ff && !pause_pend_ff && !cfg_err && !start;
  assign sample_ready = !div_wait_ff;
  assign take = sample_valid && sample_ready;
  assign last_take = take && rec_act_ff && line_ff == LINE_W'(LINES - 1);

  // stable update until 2^n records are in, then exponential
  assign use_div = is_stable ||
                   (is_expon && done_ff < (16'h1 << exp_k));
  assign direct_wr = take && rec_act_ff && !rec_skip_ff && !use_div;
  assign div_start = take && rec_act_ff && !rec_skip_ff && use_div;

  assign old_val = acc_mem[line_ff];
  assign diff = NW'($signed({sample_data[DATA_W-1], sample_data})
                - $signed({old_val[DATA_W-1], old_val}));
  assign mag = diff[NW-1] ? NW'(-diff) : diff;

  always_comb begin
    new_val = sample_data;
    if (is_expon) begin
      new_val = DATA_W'({old_val[DATA_W-1], old_val}
                + NW'($signed(diff) >>> exp_k));
    end else if (is_peak) begin
      if (done_ff != 16'h0 && $signed(sample_data) <= $signed(old_val)) begin
        new_val = old_val;
      end
    end
  end

  // mean update: old + (new - old) / n keeps equal weights
  seq_unsigned_divider #(.NW(NW), .DW(16)) u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (div_start),
    .dividend (mag),
    .divisor  (done_ff + 16'h1),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_wait_ff <= 1'b0;
      div_last_ff <= 1'b0;
      div_neg_ff <= 1'b0;
      div_line_ff <= '0;
      div_old_ff <= '0;
    end else if (div_start) begin
      div_wait_ff <= 1'b1;
      div_last_ff <= last_take;
      div_neg_ff <= diff[NW-1];
      div_line_ff <= line_ff;
      div_old_ff <= old_val;
    end else if (div_done) begin
      div_wait_ff <= 1'b0;
    end
  end

  assign wr_fire = direct_wr || div_done;
  assign wr_line = div_done ? div_line_ff : line_ff;
  assign wr_val = !div_done ? new_val : div_neg_ff ?
                  DATA_W'(div_old_ff - div_q[DATA_W-1:0]) :
                  DATA_W'(div_old_ff + div_q[DATA_W-1:0]);

  always_ff @(posedge pclk) begin
    if (wr_fire) acc_mem[wr_line] <= wr_val;
  end

  assign rec_done = (last_take && !rec_skip_ff && !use_div)
                    || (div_done && div_last_ff);
  assign final_rec = counted && ({1'b0, done_ff} + 17'h1 >= {2'h0, target});
  // quick accumulate only hides intermediates of counted functions
  assign publish = !(quick_en && counted) || final_rec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_valid <= 1'b0;
      result_line <= '0;
      result_data <= '0;
      average_complete <= 1'b0;
      record_rejected <= 1'b0;
    end else begin
      result_valid <= wr_fire && publish;
      if (wr_fire) begin
        result_line <= wr_line;
        result_data <= wr_val;
      end
      average_complete <= rec_done && publish;
      record_rejected <= accept_rec && discard;
    end
  end

  // record framing and line counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_act_ff <= 1'b0;
      rec_skip_ff <= 1'b0;
      line_ff <= '0;
    end else if (start) begin
      rec_act_ff <= 1'b0;
      line_ff <= '0;
    end else if (accept_rec) begin
      rec_act_ff <= 1'b1;
      rec_skip_ff <= discard;
      line_ff <= '0;
    end else if (take && rec_act_ff) begin
      line_ff <= last_take ? '0 : line_ff + 1'b1;
      if (last_take) rec_act_ff <= 1'b0;
    end
  end

  // clean records counted; saturates so the exponential run never falls back to the stable update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= '0;
    end else if (start) begin
      done_ff <= '0;
    end else if (rec_done && !is_off && done_ff != 16'hffff) begin
      done_ff <= done_ff + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_pend_ff <= 1'b0;
    end else if (start || state_ff != ST_RUN) begin
      pause_pend_ff <= 1'b0;
    end else if (halt_cmd || sel_off) begin
      pause_pend_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (rec_done && final_rec) begin
          nxt_state = ST_DONE;
        end else if (pause_pend_ff && !rec_act_ff && !div_wait_ff) begin
          nxt_state = ST_PAUSED;
        end
      end
      ST_PAUSED: if (halt_cmd) nxt_state = ST_RUN;
      ST_DONE:   nxt_state = ST_DONE;
      default:   nxt_state = ST_RUN;
    endcase
    if (start) nxt_state = ST_RUN;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_ff <= ST_RUN;
    else state_ff <= nxt_state;
  end

  assign measurement_halted = (state_ff != ST_RUN);

  // processing time per record and spacing of the last two records
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_cnt_ff <= '0;
      proc_ff <= '0;
      gap_cnt_ff <= '0;
      gap_ff <= '0;
    end else begin
      if (accept_rec) proc_cnt_ff <= 32'h1;
      else if (proc_cnt_ff != 32'hffffffff) proc_cnt_ff <= proc_cnt_ff + 1'b1;
      if (rec_done) proc_ff <= proc_cnt_ff;
      if (record_valid) begin
        gap_ff <= gap_cnt_ff;
        gap_cnt_ff <= 32'h1;
      end else if (gap_cnt_ff != 32'hffffffff) begin
        gap_cnt_ff <= gap_cnt_ff + 1'b1;
      end
    end
  end

  assign grant_cap = is_off ? OVL_MAX_PCT : ovl_cfg_ff;
  // without free run the fill is treated as zero, so no overlap fits
  assign grant_fill = trigger_free_run ? record_fill_cycles : '0;

  overlap_percent_search #(.CW(32)) u_grant (
    .pclk    (pclk),
    .presetn (presetn),
    .cap     (grant_cap),
    .fill    (grant_fill),
    .gap     (proc_ff),
    .pct     (overlap_grant_pct)
  );

  overlap_percent_search #(.CW(32)) u_achieved (
    .pclk    (pclk),
    .presetn (presetn),
    .cap     (grant_cap),
    .fill    (grant_fill),
    .gap     (gap_ff),
    .pct     (ovl_achieved)
  );

  // helper: cycles without free run, saturating
  logic [7:0] nf_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nf_cnt_ff <= '0;
    else if (trigger_free_run) nf_cnt_ff <= '0;
    else if (nf_cnt_ff != 8'hff) nf_cnt_ff <= nf_cnt_ff + 8'h1;
  end

  sequence s_last_record;
    state_ff == ST_RUN && rec_done && final_rec && !start;
  endsequence
  sequence s_halted_two;
    state_ff == ST_DONE ##1 (measurement_halted || $past(start));
  endsequence

  chk_stop_count: assert property (@(posedge pclk) disable iff (!presetn)
    s_last_record |=> s_halted_two)
    else $error("count reached but measurement kept running");

  chk_expon_cap: assert property (@(posedge pclk) disable iff (!presetn)
    is_expon |-> target <= EXPON_COUNT_MAX && target != 15'h0)
    else $error("exponential count out of range");

  chk_expon_pow2: assert property (@(posedge pclk) disable iff (!presetn)
    is_expon |-> ({1'b0, target} <= (16'h1 << exp_k)) && (exp_k == 4'h0
    || {1'b0, target} > (16'h1 << (exp_k - 4'h1))))
    else $error("exponential constant not next power of two");

  chk_no_stop_free: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_ff == ST_DONE) |-> $past(counted))
    else $error("uncounted function stopped on count");

  chk_reject_flag: assert property (@(posedge pclk) disable iff (!presetn)
    accept_rec && discard |=> record_rejected && rec_skip_ff)
    else $error("overrange record not rejected");

  chk_pause_done: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_RUN && pause_pend_ff && !rec_act_ff && !div_wait_ff
    && !start && !(rec_done && final_rec) |=> state_ff == ST_PAUSED)
    else $error("pause did not take effect after record");

  chk_restart_clr: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> done_ff == 16'h0 && state_ff == ST_RUN)
    else $error("restart did not clear the average");

  chk_no_freerun: assert property (@(posedge pclk) disable iff (!presetn)
    nf_cnt_ff > 8'h64 |-> overlap_grant_pct == 7'h00)
    else $error("overlap granted without free run");

  chk_ovl_limit: assert property (@(posedge pclk) disable iff (!presetn)
    ovl_cfg_ff <= OVL_MAX_PCT ##0 overlap_grant_pct <= OVL_MAX_PCT)
    else $error("overlap above ninety percent");

  chk_off_publish: assert property (@(posedge pclk) disable iff (!presetn)
    is_off && direct_wr |=> result_valid && result_data == $past(sample_data))
    else $error("unaveraged record not written through");

endmodule // spectrum_averaging_engine

//--- record_source.sv
// upstream record source: strobe with overrange flag, then four samples
// assumes the engine is built with four lines of 24-bit data
`timescale 1ns/1ps
module record_source (
  input  wire logic   pclk,
  input  wire logic   sample_ready,
  output logic        record_valid,
  output logic        record_overrange,
  output logic        sample_valid,
  output logic [23:0] sample_data
);
  initial begin
    record_valid = 1'b0;
    record_overrange = 1'b0;
    sample_valid = 1'b0;
    sample_data = 24'h000000;
  end

  // released lines show the inverse so stale values never match
  task automatic send(input logic ovr, input logic [23:0] d [4]);
    int w;
    @(posedge pclk);
    record_valid <= 1'b1;
    record_overrange <= ovr;
    @(posedge pclk);
    record_valid <= 1'b0;
    record_overrange <= ~ovr;
    for (int k = 0; k < 4; k++) begin
      w = 0;
      sample_valid <= 1'b1;
      sample_data <= d[k];
      do @(posedge pclk); while (sample_ready !== 1'b1 && ++w < 200);
      if (w >= 200) spectrum_averaging_engine_tb.err_count++;
    end
    sample_valid <= 1'b0;
    sample_data <= ~d[3];
  endtask
endmodule // record_source

//--- spectrum_averaging_engine_tb.sv
// self-checking bench: apb master, record source, result scoreboard
// assumes four lines per record and zero-wait apb answers
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module spectrum_averaging_engine_tb import avg_engine_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, record_fill_cycles, seed, r;
  logic        trigger_free_run, record_valid, record_overrange, e;
  logic        sample_valid, sample_ready, record_rejected, result_valid;
  logic        average_complete, measurement_halted;
  logic [23:0] sample_data, result_data, e_v;
  logic [23:0] prev [4];
  logic [1:0]  result_line;
  logic [6:0]  overlap_grant_pct;
  logic [23:0] exp_q [$];
  int          err_count, checks_done, rej_seen;

  spectrum_averaging_engine #(.DATA_W(24), .LINES(4), .LINE_W(2))
    i_spectrum_averaging_engine (.*);
  record_source i_record_source (.*);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (record_rejected === 1'b1) rej_seen++;
    if (result_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(result_valid, 1'b0)
      else begin
        e_v = exp_q.pop_front();
        `CHK(result_data, e_v)
      end
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(r, x)
  endtask

  // kind 0 publishes samples, 1 nothing, 2 the mean of two, 3 the larger;
  // the mean step is truncated, so it rounds toward the old value
  task automatic rec(input logic ovr, input int kind);
    logic [23:0] d [4];
    int n;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      d[k] = seed[23:0] & 24'h0fffff;
      if (kind == 0) exp_q.push_back(d[k]);
      if (kind == 2) exp_q.push_back(d[k] >= prev[k] ?
          prev[k] + (d[k] - prev[k]) / 2 : prev[k] - (prev[k] - d[k]) / 2);
      if (kind == 3) exp_q.push_back(d[k] > prev[k] ? d[k] : prev[k]);
      if (kind == 0) prev[k] = d[k];
    end
    i_record_source.send(ovr, d);
    n = 0;
    while (exp_q.size() != 0 && ++n < 600) @(posedge pclk);
    `CHK(exp_q.size(), 0)
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    trigger_free_run = 1'b0;
    record_fill_cycles = 32'h0;
    seed = 32'hd95310b7;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(ADDR_CTRL, 32'h0);
    rchk(ADDR_COUNT, 32'h1);
    rchk(ADDR_OVL, 32'h0);
    rchk(ADDR_STAT, 32'h1);
    apb(1'b1, ADDR_OVL, 32'h64);
    rchk(ADDR_OVL, 32'h5a);
    apb(1'b0, 8'h40, 32'h0);
    `CHK({e, r}, 33'h100000000)
    $display("test registers ended");
    apb(1'b1, ADDR_CTRL, 32'h10);
    rec(1'b1, 0);
    `CHK(rej_seen, 0)
    trigger_free_run <= 1'b1;
    record_fill_cycles <= 32'h1000;
    repeat (100) @(posedge pclk);
    `CHK(overlap_grant_pct, 7'h5a)
    trigger_free_run <= 1'b0;
    repeat (100) @(posedge pclk);
    `CHK(overlap_grant_pct, 7'h00)
    $display("test unaveraged ended");
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_COUNT, 32'd25);
    rchk(ADDR_EXPK, 32'h5);
    apb(1'b1, ADDR_COUNT, 32'd20000);
    rchk(ADDR_EXPK, 32'he);
    $display("test exponential ended");
    apb(1'b1, ADDR_COUNT, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h11);
    apb(1'b1, ADDR_CMD, 32'h2);
    rec(1'b1, 1);
    `CHK(rej_seen, 1)
    rec(1'b0, 0);
    rec(1'b0, 2);
    rchk(ADDR_DONE, 32'h2);
    `CHK(measurement_halted, 1'b1)
    rec(1'b0, 1);
    repeat (60) @(posedge pclk);
    $display("test stable ended");
    apb(1'b1, ADDR_CMD, 32'h2);
    apb(1'b1, ADDR_CMD, 32'h1);
    rec(1'b0, 1);
    rchk(ADDR_STAT, 32'h2);
    apb(1'b1, ADDR_CMD, 32'h1);
    rchk(ADDR_STAT, 32'h1);
    rec(1'b0, 0);
    $display("test pause ended");
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_CMD, 32'h2);
    rec(1'b0, 0);
    rec(1'b0, 3);
    `CHK(measurement_halted, 1'b1)
    $display("test peak ended");
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    print_verdict();
  end
endmodule // spectrum_averaging_engine_tb
